// ---- testbench.sv ----
// Self-checking bench comparing the port block with a register model.
`timescale 1ns/1ps
module testbench;
  logic       clk_i = 0, reset_i = 1, wr_i = 0, rd_i = 0;
  logic [7:0] addr_i = 0, wdata_i = 0, rdata_o;
  logic [2:0] conv_chan_i = 7;
  logic [5:0] ana_pin_i, ana_pin_o, ana_pin_oe_o, ana_analog_o;
  logic [5:0] ax = 0, al, ad = 0, sel = 0;
  logic [1:0] pair_pin_i, pair_pin_o, pair_pin_oe_o, pair_pullup_o;
  logic [1:0] px = 0, pe = 3, pl, pd = 0, pu = 0;
  int         seed = 57344, miscompares = 0, checks = 0, r;
  // Clock of 40 ns period.
  always #20 clk_i = ~clk_i;
  tpg_ports DUT (.clk_i, .reset_i, .addr_i, .wdata_i, .wr_i, .rd_i,
    .rdata_o, .conv_chan_i, .ana_pin_i, .ana_pin_o, .ana_pin_oe_o,
    .ana_analog_o, .pair_pin_i, .pair_pin_o, .pair_pin_oe_o,
    .pair_pullup_o);
  tpg_pins pins (.ana_o_i(ana_pin_o), .ana_oe_i(ana_pin_oe_o),
    .ana_ext_i(ax), .pair_o_i(pair_pin_o), .pair_oe_i(pair_pin_oe_o),
    .pair_pu_i(pair_pullup_o), .pair_ext_i(px), .pair_ext_en_i(pe),
    .ana_lvl_o(ana_pin_i), .pair_lvl_o(pair_pin_i));
  task automatic final_report();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(string n, logic [7:0] e, logic [7:0] g);
    checks++;
    if (g !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge clk_i);
    wr_i <= 1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_i);
    wr_i <= 0;
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] e, string n);
    @(posedge clk_i);
    rd_i <= 1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i <= 0;
    #1 chk(n, e, rdata_o);
  endtask
  // Lets pins settle, then compares pad controls and every register.
  task automatic check_all();
    repeat (6) @(posedge clk_i);
    #1 chk("ana_oe", {2'h0, ad & ~sel}, {2'h0, ana_pin_oe_o});
    chk("ana_sel", {2'h0, sel}, {2'h0, ana_analog_o});
    chk("ana_drv", {2'h0, al & ad & ~sel},
      {2'h0, ana_pin_o & ana_pin_oe_o});
    chk("pair_drv", {4'h0, pd, pl & pd},
      {4'h0, pair_pin_oe_o, pair_pin_o & pair_pin_oe_o});
    chk("pullup", {6'h0, pu & ~pd}, {6'h0, pair_pullup_o});
    rd(tpg_pkg::ANA_DATA_ADDR, {2'h0, al & ad | ax & ~ad}, "ana");
    rd(tpg_pkg::PAIR_DATA_ADDR,
      {6'h0, pl & pd | (pe & px | ~pe) & ~pd}, "pair");
    rd(tpg_pkg::ANA_DIR_ADDR, {2'h0, ad}, "ana_dir");
    rd(tpg_pkg::PAIR_DIR_ADDR, {6'h0, pd}, "pair_dir");
    rd(tpg_pkg::PAIR_PULLUP_ADDR, {6'h0, pu}, "pullup_reg");
    rd(8'h07, 8'h00, "unmapped");
  endtask
  // Watchdog well beyond the expected run length.
  initial begin
    #3000000 miscompares++;
    final_report();
  end
  // Reset, random configurations, then a reset in mid-run.
  initial begin
    repeat (4) @(posedge clk_i);
    reset_i <= 0;
    check_all();
    for (int i = 0; i < 40; i++) begin
      r = $random(seed);
      al = r[5:0];
      pl = r[7:6];
      ad = r[13:8];
      pd = r[15:14];
      pu = r[17:16];
      wr(tpg_pkg::ANA_DATA_ADDR, r[7:0]);
      wr(tpg_pkg::PAIR_DATA_ADDR, {r[5:0], r[7:6]});
      wr(tpg_pkg::ANA_DIR_ADDR, r[15:8]);
      wr(tpg_pkg::PAIR_DIR_ADDR, {r[13:8], r[15:14]});
      wr(tpg_pkg::PAIR_PULLUP_ADDR, {r[13:8], r[17:16]});
      ax <= r[23:18];
      px <= r[25:24];
      pe <= r[27:26] | ~pu;
      conv_chan_i <= r[30:28];
      sel = (r[30:28] < 6) ? 6'h1 << r[30:28] : 6'h0;
      check_all();
    end
    $display("random test done");
    reset_i <= 1;
    repeat (4) @(posedge clk_i);
    chk("reset_oe", 8'h00, {ana_pin_oe_o, pair_pin_oe_o});
    reset_i <= 0;
    pe <= 3;
    {ad, pd, pu} = 10'h000;
    check_all();
    wr(tpg_pkg::ANA_DIR_ADDR, 8'hff);
    wr(tpg_pkg::PAIR_DIR_ADDR, 8'hff);
    {ad, pd} = 8'hff;
    check_all();
    $display("reset test done");
    final_report();
  end
endmodule

// ---- tpg_pins.sv ----
// Pad model: resolves each pin from chip drive and outside drive, pair pins also from pullup.
`timescale 1ns/1ps
module tpg_pins (
  input  wire logic [5:0] ana_o_i,
  input  wire logic [5:0] ana_oe_i,
  input  wire logic [5:0] ana_ext_i,
  input  wire logic [1:0] pair_o_i,
  input  wire logic [1:0] pair_oe_i,
  input  wire logic [1:0] pair_pu_i,
  input  wire logic [1:0] pair_ext_i,
  input  wire logic [1:0] pair_ext_en_i,
  output logic      [5:0] ana_lvl_o,
  output logic      [1:0] pair_lvl_o
);
  logic [1:0] pair_free;
  // A driven pad follows the chip; a released one follows the outside.
  assign ana_lvl_o = (ana_oe_i & ana_o_i) | (~ana_oe_i & ana_ext_i);
  // Undriven pair pads without outside drive go high with a pullup, else to the inverse of pair_ext_i.
  assign pair_free = pair_pu_i | ~pair_ext_i;
  assign pair_lvl_o = (pair_oe_i & pair_o_i) | (~pair_oe_i &
    ((pair_ext_en_i & pair_ext_i) | (~pair_ext_en_i & pair_free)));
endmodule

// ---- tpg_pkg.sv ----
// Package with register map, field layout and reset values for the ports.
// Functional notes
// - Analog port has six latched data pins.
// - Analog data at 0x01, upper bits zero.
// - Reset leaves analog port latches unchanged.
// - Converter channel select forces pin analog input.
// - Direction 1 drives latch, 0 makes input.
// - Analog direction at 0x05, reset clears.
// - Data writes always update latches.
// - Pair port has two latched pins, reset-immune.
// - Pair direction two bits, reset clears.
// - Pair pins offer pullup while input.
// - Pullup bit 1 connects, 0 disconnects.
// - Output direction disables pullup automatically.
package tpg_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned ANA_W = 6;
  localparam int unsigned PAIR_W = 2;
  localparam logic [7:0] ANA_DATA_ADDR = 8'h01;
  localparam logic [7:0] PAIR_DATA_ADDR = 8'h02;
  localparam logic [7:0] ANA_DIR_ADDR = 8'h05;
  localparam logic [7:0] PAIR_DIR_ADDR = 8'h06;
  localparam logic [7:0] PAIR_PULLUP_ADDR = 8'h0e;
  localparam logic [7:0] CHAN_SEL_ADDR = 8'h07;
  localparam logic [5:0] ANA_DIR_RESET = 6'h00;
  localparam logic [1:0] PAIR_DIR_RESET = 2'h0;
  localparam logic [1:0] PAIR_PULLUP_RESET = 2'h0;
  localparam logic [2:0] CHAN_NONE = 3'h7;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;
endpackage

// ---- tpg_ports.sv ----
// Two general-purpose ports with register access and pin control.
`timescale 1ns/1ps
module tpg_ports (
  input  wire logic       clk_i,
  input  wire logic       reset_i,
  input  wire logic [7:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  output logic      [7:0] rdata_o,
  input  wire logic [2:0] conv_chan_i,
  input  wire logic [5:0] ana_pin_i,
  output logic      [5:0] ana_pin_o,
  output logic      [5:0] ana_pin_oe_o,
  output logic      [5:0] ana_analog_o,
  input  wire logic [1:0] pair_pin_i,
  output logic      [1:0] pair_pin_o,
  output logic      [1:0] pair_pin_oe_o,
  output logic      [1:0] pair_pullup_o
);

  // Register state; latches are without reset on purpose.
  logic [5:0] ana_latch_q;
  logic [5:0] ana_dir_q;
  logic [1:0] pair_latch_q;
  logic [1:0] pair_dir_q;
  logic [1:0] pair_pull_q;
  logic [5:0] ana_s1_q, ana_s2_q, ana_s3_q, ana_lvl_q;
  logic [1:0] pair_s1_q, pair_s2_q, pair_s3_q, pair_lvl_q;

  // Address decode for writes.
  wire we_ana_data  = wr_i && (addr_i == tpg_pkg::ANA_DATA_ADDR);
  wire we_pair_data = wr_i && (addr_i == tpg_pkg::PAIR_DATA_ADDR);
  wire we_ana_dir   = wr_i && (addr_i == tpg_pkg::ANA_DIR_ADDR);
  wire we_pair_dir  = wr_i && (addr_i == tpg_pkg::PAIR_DIR_ADDR);
  wire we_pair_pull = wr_i && (addr_i == tpg_pkg::PAIR_PULLUP_ADDR);

  // One-hot decode of the converter channel onto the analog pins.
  wire [5:0] ana_sel;
  genvar g;
  generate
    for (g = 0; g < 6; g++) begin : g_sel
      assign ana_sel[g] = (conv_chan_i == 3'(g));
    end
  endgenerate

  // Read-back mixes latch and filtered pin level per direction bit.
  wire [5:0] ana_read  = (ana_dir_q & ana_latch_q)
                       | (~ana_dir_q & ana_lvl_q);
  wire [1:0] pair_read = (pair_dir_q & pair_latch_q)
                       | (~pair_dir_q & pair_lvl_q);
  wire [7:0] rd_mux =
    (addr_i == tpg_pkg::ANA_DATA_ADDR)    ? {2'h0, ana_read} :
    (addr_i == tpg_pkg::PAIR_DATA_ADDR)   ? {6'h00, pair_read} :
    (addr_i == tpg_pkg::ANA_DIR_ADDR)     ? {2'h0, ana_dir_q} :
    (addr_i == tpg_pkg::PAIR_DIR_ADDR)    ? {6'h00, pair_dir_q} :
    (addr_i == tpg_pkg::PAIR_PULLUP_ADDR) ? {6'h00, pair_pull_q} :
    tpg_pkg::UNMAPPED_READ;

  // Pin drive terms; channel select overrides direction.
  wire [5:0] ana_oe_d  = ana_dir_q & ~ana_sel;
  wire [1:0] pair_pu_d = pair_pull_q & ~pair_dir_q;

  // Data latches load on every write, whatever the direction.
  always_ff @(posedge clk_i) begin
    if (we_ana_data) begin
      ana_latch_q <= wdata_i[5:0];
    end
    if (we_pair_data) begin
      pair_latch_q <= wdata_i[1:0];
    end
  end

  // Control registers cleared by reset.
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      ana_dir_q   <= tpg_pkg::ANA_DIR_RESET;
      pair_dir_q  <= tpg_pkg::PAIR_DIR_RESET;
      pair_pull_q <= tpg_pkg::PAIR_PULLUP_RESET;
    end else begin
      if (we_ana_dir) begin
        ana_dir_q <= wdata_i[5:0];
      end
      if (we_pair_dir) begin
        pair_dir_q <= wdata_i[1:0];
      end
      if (we_pair_pull) begin
        pair_pull_q <= wdata_i[1:0];
      end
    end
  end

  // Pin synchronisers; level changes once stages two and three agree.
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      ana_s1_q   <= 6'h00;
      ana_s2_q   <= 6'h00;
      ana_s3_q   <= 6'h00;
      ana_lvl_q  <= 6'h00;
      pair_s1_q  <= 2'h0;
      pair_s2_q  <= 2'h0;
      pair_s3_q  <= 2'h0;
      pair_lvl_q <= 2'h0;
    end else begin
      ana_s1_q   <= ana_pin_i;
      ana_s2_q   <= ana_s1_q;
      ana_s3_q   <= ana_s2_q;
      ana_lvl_q  <= (ana_s2_q & ana_s3_q)
                  | (ana_lvl_q & (ana_s2_q ^ ana_s3_q));
      pair_s1_q  <= pair_pin_i;
      pair_s2_q  <= pair_s1_q;
      pair_s3_q  <= pair_s2_q;
      pair_lvl_q <= (pair_s2_q & pair_s3_q)
                  | (pair_lvl_q & (pair_s2_q ^ pair_s3_q));
    end
  end

  // Registered outputs: read data and pin controls.
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      rdata_o       <= 8'h00;
      ana_pin_o     <= 6'h00;
      ana_pin_oe_o  <= 6'h00;
      ana_analog_o  <= 6'h00;
      pair_pin_o    <= 2'h0;
      pair_pin_oe_o <= 2'h0;
      pair_pullup_o <= 2'h0;
    end else begin
      rdata_o       <= rd_i ? rd_mux : 8'h00;
      ana_pin_o     <= ana_latch_q;
      ana_pin_oe_o  <= ana_oe_d;
      ana_analog_o  <= ana_sel;
      pair_pin_o    <= pair_latch_q;
      pair_pin_oe_o <= pair_dir_q;
      pair_pullup_o <= pair_pu_d;
    end
  end

  // Checks on the block's own behaviour.
  AST_ANA_OE_DIR: assert property (@(posedge clk_i) disable iff (reset_i)
    ##1 ana_pin_oe_o == ($past(ana_dir_q) & ~$past(ana_sel)))
    else $error("analog output enable wrong");
  AST_SEL_OVERRIDE: assert property (@(posedge clk_i) disable iff (reset_i)
    (ana_sel != 6'h00) |=> (((ana_pin_oe_o & $past(ana_sel)) == 6'h00)
      && (ana_analog_o == $past(ana_sel))))
    else $error("selected channel still driven");
  AST_ANA_RD_HI: assert property (@(posedge clk_i) disable iff (reset_i)
    (rd_i && addr_i == tpg_pkg::ANA_DATA_ADDR) |=> rdata_o[7:6] == 2'h0)
    else $error("analog data upper bits not zero");
  AST_ANA_WR: assert property (@(posedge clk_i) disable iff (reset_i)
    we_ana_data |=> ana_latch_q == $past(wdata_i[5:0]))
    else $error("analog latch not written");
  AST_ANA_RD: assert property (@(posedge clk_i) disable iff (reset_i)
    (rd_i && addr_i == tpg_pkg::ANA_DATA_ADDR) |=>
      rdata_o[5:0] == $past(ana_read))
    else $error("analog read mix wrong");
  AST_PAIR_RD: assert property (@(posedge clk_i) disable iff (reset_i)
    (rd_i && addr_i == tpg_pkg::PAIR_DATA_ADDR) |=>
      rdata_o == {6'h00, $past(pair_read)})
    else $error("pair read mix wrong");
  AST_PULL_OFF: assert property (@(posedge clk_i) disable iff (reset_i)
    ##1 (pair_pullup_o & $past(pair_dir_q)) == 2'h0)
    else $error("pullup on an output pin");
  AST_PAIR_DIR: assert property (@(posedge clk_i) disable iff (reset_i)
    we_pair_dir |=> pair_dir_q == $past(wdata_i[1:0]))
    else $error("pair direction not written");
  AST_ANA_DIR_RST: assert property (@(posedge clk_i)
    $fell(reset_i) |-> ana_dir_q == 6'h00)
    else $error("analog direction not cleared");

  // True for every address that holds a register of this block.
  function automatic logic addr_mapped(input logic [7:0] a);
    addr_mapped = (a == tpg_pkg::ANA_DATA_ADDR)
               || (a == tpg_pkg::PAIR_DATA_ADDR)
               || (a == tpg_pkg::ANA_DIR_ADDR)
               || (a == tpg_pkg::PAIR_DIR_ADDR)
               || (a == tpg_pkg::PAIR_PULLUP_ADDR);
  endfunction

  // A read strobe aimed at a given address.
  sequence s_rd_at(logic [7:0] a);
    rd_i && (addr_i == a);
  endsequence

  // A direction write that lands while no channel is selected.
  sequence s_dir_free;
    we_ana_dir ##1 (ana_sel == 6'h00);
  endsequence

  // A data write followed by the cycle in which the latch holds it.
  sequence s_ana_latched;
    we_ana_data ##1 (ana_latch_q == $past(wdata_i[5:0]));
  endsequence

  // The pair latch follows every data write, whatever the direction.
  AST_PAIR_WR: assert property (@(posedge clk_i) disable iff (reset_i)
    we_pair_data |=> pair_latch_q == $past(wdata_i[1:0]))
    else $error("pair latch not written");

  // The analog direction register takes the low six bits of a write.
  AST_ANA_DIR_WR: assert property (@(posedge clk_i) disable iff (reset_i)
    we_ana_dir |=> ana_dir_q == $past(wdata_i[5:0]))
    else $error("analog direction not written");

  // The pullup enable register takes the low two bits of a write.
  AST_PULL_WR: assert property (@(posedge clk_i) disable iff (reset_i)
    we_pair_pull |=> pair_pull_q == $past(wdata_i[1:0]))
    else $error("pullup enable not written");

  // A pullup is connected exactly when enabled on an input pin.
  AST_PULL_ON: assert property (@(posedge clk_i) disable iff (reset_i)
    ##1 pair_pullup_o == ($past(pair_pull_q) & ~$past(pair_dir_q)))
    else $error("pullup connect wrong");

  // The pair drive enables copy the direction bits one cycle later.
  AST_PAIR_OE: assert property (@(posedge clk_i) disable iff (reset_i)
    ##1 pair_pin_oe_o == $past(pair_dir_q))
    else $error("pair output enable wrong");

  // Written analog data reaches the pin drive two cycles later.
  AST_ANA_DRV: assert property (@(posedge clk_i) disable iff (reset_i)
    s_ana_latched |=> ana_pin_o == $past(wdata_i[5:0], 2))
    else $error("analog drive value wrong");

  // Written pair data reaches the pin drive two cycles later.
  AST_PAIR_DRV: assert property (@(posedge clk_i) disable iff (reset_i)
    we_pair_data |=> ##1 pair_pin_o == $past(wdata_i[1:0], 2))
    else $error("pair drive value wrong");

  // A new direction reaches the pads when no channel claims a pin.
  AST_DIR_TO_PIN: assert property (@(posedge clk_i) disable iff (reset_i)
    s_dir_free |=> ana_pin_oe_o == $past(ana_dir_q))
    else $error("direction not applied to pins");

  // At most one analog pin is handed to the converter.
  AST_SEL_ONEHOT: assert property (@(posedge clk_i) disable iff (reset_i)
    $onehot0(ana_sel))
    else $error("more than one channel selected");

  // Channel codes beyond the sixth pin select nothing.
  AST_SEL_NONE: assert property (@(posedge clk_i) disable iff (reset_i)
    (conv_chan_i > 3'h5) |-> (ana_sel == 6'h00))
    else $error("out of range channel selected a pin");

  // The read data bus rests at zero outside the answer cycle.
  AST_RD_IDLE: assert property (@(posedge clk_i) disable iff (reset_i)
    !rd_i |=> rdata_o == 8'h00)
    else $error("read data not idle");

  // Unmapped addresses read back as zero.
  AST_RD_UNMAPPED: assert property (@(posedge clk_i) disable iff (reset_i)
    (rd_i && !addr_mapped(addr_i)) |=> rdata_o == 8'h00)
    else $error("unmapped read not zero");

  // A pair direction read answers with the upper six bits zero.
  AST_PAIR_RD_HI: assert property (@(posedge clk_i) disable iff (reset_i)
    s_rd_at(tpg_pkg::PAIR_DIR_ADDR) |=> rdata_o[7:2] == 6'h00)
    else $error("pair direction upper bits not zero");

  // Analog direction reads return the six stored bits only.
  AST_ANA_DIR_RD: assert property (@(posedge clk_i) disable iff (reset_i)
    s_rd_at(tpg_pkg::ANA_DIR_ADDR) |=>
      rdata_o == {2'h0, $past(ana_dir_q)})
    else $error("analog direction read wrong");

  // Pullup enable reads return the two stored bits.
  AST_PULL_RD: assert property (@(posedge clk_i) disable iff (reset_i)
    s_rd_at(tpg_pkg::PAIR_PULLUP_ADDR) |=>
      rdata_o == {6'h00, $past(pair_pull_q)})
    else $error("pullup enable read wrong");

  // Reset leaves the pair direction cleared.
  AST_PAIR_DIR_RST: assert property (@(posedge clk_i)
    $fell(reset_i) |-> pair_dir_q == 2'h0)
    else $error("pair direction not cleared");

  // No pin is driven and no pullup connected as reset ends.
  AST_OUT_RST: assert property (@(posedge clk_i)
    $fell(reset_i) |-> (ana_pin_oe_o == 6'h00) && (pair_pin_oe_o == 2'h0)
      && (pair_pullup_o == 2'h0))
    else $error("pins active after reset");

  // The filtered analog level takes the stage two value where stages two and three agree.
  AST_ANA_FILTER: assert property (@(posedge clk_i) disable iff (reset_i)
    ##1 ((ana_lvl_q ^ $past(ana_s2_q))
      & ~$past(ana_s2_q ^ ana_s3_q)) == 6'h00)
    else $error("analog level filter wrong");

  // The filtered analog level holds where stages two and three differ.
  AST_ANA_HOLD: assert property (@(posedge clk_i) disable iff (reset_i)
    ##1 ((ana_lvl_q ^ $past(ana_lvl_q))
      & $past(ana_s2_q ^ ana_s3_q)) == 6'h00)
    else $error("analog level moved on disagreement");

  // The filtered pair level follows agreeing stages.
  AST_PAIR_FILTER: assert property (@(posedge clk_i) disable iff (reset_i)
    ##1 ((pair_lvl_q ^ $past(pair_s2_q))
      & ~$past(pair_s2_q ^ pair_s3_q)) == 2'h0)
    else $error("pair level filter wrong");

endmodule
